/* File: verilog/rtc_trim_defines.svh */
// Purpose: Constants for the one-second trim unit
// Assumes: 8-bit registers, 4-bit register address
// Notes:   Contract list below
//
// Contract
// (RL1) Period-select 0: one second per 20 is corrected
// (RL2) Period-select 1: one second per 60 is corrected
// (RL3) Middle five trim bits all zero means no correction at all
// (RL4) Trim bits form a signed 7-bit code, bit 6 most significant
// (RL5) Positive code slows the count by code minus one steps
// (RL6) Loss of N is coded 128 minus N; top bit set decodes so
// (RL7) Host computes code from frequency error times 10 or 30, plus one if fast
// (RL8) Host writes only codes from -62 to 63
// (RL9) Step is about 3 ppm on 20 s period, 1 ppm on 60 s period
// (RL10) Control register 1 at Eh set to 00xx0011 gives 1 Hz pulse output
// (RL11) One altered 1 Hz period per 20 or 60 periods
// (RL12) Host avoids unsynchronised access more than twice a second while trimming
// (RL13) Power-up flag clears period-select and all trim bits
// (RL14) Correction adds or removes prescaler ticks in the chosen second only
`ifndef RTC_TRIM_DEFINES_SVH
`define RTC_TRIM_DEFINES_SVH

`define TRIM_ADDR        4'h7
`define CTRL1_ADDR       4'he
`define TRIM_RESET       8'h00
`define CTRL1_RESET      8'h00
`define PERIOD_SEL_BIT   7
`define CTRL1_PULSE_MASK 8'hcf
`define CTRL1_PULSE_VAL  8'h03
`define XTAL_HZ          32768
`define STEP_TICKS       2
`define PERIOD_SHORT     6'h14
`define PERIOD_LONG      6'h3c
`define LOSS_BASE        128

`endif

/* File: verilog/rtc_trim_pkg.sv */
// Purpose: Types for the one-second trim unit
// Assumes: Nothing
// Notes:   Constants live in rtc_trim_defines.svh
package rtc_trim_pkg;
    typedef logic [6:0] trim_code_t;
    typedef enum logic [1:0] {CORR_NONE, CORR_SLOW, CORR_FAST} corr_kind_t;
endpackage

/* File: verilog/rtc_second_trim_unit.sv */
// Purpose: Trims the one-second timebase and drives the 1 Hz pulse output
// Assumes: xtal_tick is a one-cycle pulse per 32.768 kHz crystal period
// Notes:   One step is two prescaler ticks
`timescale 1ns/1ps
`include "rtc_trim_defines.svh"

module rtc_second_trim_unit
    import rtc_trim_pkg::*;
#(
    parameter int TICKS_PER_SEC = `XTAL_HZ
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       xtal_tick,
    input  wire logic       power_up_flag,
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            second_pulse,
    output logic            interrupt_output_pin_n
);
    localparam int CW   = $clog2(TICKS_PER_SEC + 256) + 1;
    localparam int HALF = TICKS_PER_SEC / 2;

    logic [7:0]    trim_reg;
    logic [7:0]    ctrl1_reg;
    logic [CW-1:0] tick_cnt_reg;
    logic [CW-1:0] len_reg;
    logic [5:0]    sec_idx_reg;
    logic          pulse_n_reg;
    logic          sec_pulse_reg;
    logic [7:0]    rdata_reg;

    function automatic corr_kind_t corr_kind(input trim_code_t c);
        if (c[5:1] == 5'h00) begin
            return CORR_NONE;                                // [RL3]
        end
        return c[6] ? CORR_FAST : CORR_SLOW;                 // [RL4]
    endfunction

    function automatic logic [CW-1:0] sec_len(input trim_code_t c, input logic adjusted);
        int n;
        n = TICKS_PER_SEC;
        if (adjusted) begin
            unique case (corr_kind(c))
                CORR_SLOW: n = TICKS_PER_SEC + `STEP_TICKS * (int'(c) - 1);                 // [RL5]
                CORR_FAST: n = TICKS_PER_SEC - `STEP_TICKS * (`LOSS_BASE - int'(c));        // [RL6]
                CORR_NONE: n = TICKS_PER_SEC;
            endcase
        end
        return n[CW-1:0];
    endfunction

    wire           period_sel  = trim_reg[`PERIOD_SEL_BIT];
    wire [5:0]     period      = period_sel ? `PERIOD_LONG : `PERIOD_SHORT;   // [RL1] [RL2]
    wire           sec_end     = xtal_tick && (tick_cnt_reg == len_reg - 1'b1);
    wire [5:0]     idx_next    = (sec_idx_reg >= period - 6'h01) ? 6'h00 : sec_idx_reg + 6'h01;
    wire [CW-1:0]  len_next    = sec_len(trim_reg[6:0], idx_next == 6'h00);  // [RL11] [RL14]
    wire           pulse_en    = (ctrl1_reg & `CTRL1_PULSE_MASK) == `CTRL1_PULSE_VAL;
    wire           trim_sel    = reg_addr == `TRIM_ADDR;
    wire           ctrl1_sel   = reg_addr == `CTRL1_ADDR;
    wire [7:0]     rd_mux      = trim_sel ? trim_reg : (ctrl1_sel ? ctrl1_reg : 8'h00);
    wire           first_half  = tick_cnt_reg < HALF[CW-1:0];

    // Power-up wins over a write in the same cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_reg  <= `TRIM_RESET;
            ctrl1_reg <= `CTRL1_RESET;
        end else if (power_up_flag) begin
            trim_reg  <= `TRIM_RESET;                        // [RL13]
            ctrl1_reg <= `CTRL1_RESET;
        end else if (reg_wr) begin
            trim_reg  <= trim_sel ? reg_wdata : trim_reg;
            ctrl1_reg <= ctrl1_sel ? reg_wdata : ctrl1_reg;
        end
    end

    // Length is latched per second so mid-second writes cannot tear a second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_reg <= '0;
            len_reg      <= TICKS_PER_SEC[CW-1:0];
            sec_idx_reg  <= 6'h00;
        end else if (sec_end) begin
            tick_cnt_reg <= '0;
            len_reg      <= len_next;                        // [RL14]
            sec_idx_reg  <= idx_next;                        // [RL1] [RL2]
        end else if (xtal_tick) begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pulse_n_reg   <= 1'b1;
            sec_pulse_reg <= 1'b0;
            rdata_reg     <= 8'h00;
        end else begin
            pulse_n_reg   <= !(pulse_en && first_half);      // [RL10] [RL11]
            sec_pulse_reg <= sec_end;
            rdata_reg     <= rd_mux;
        end
    end

    assign reg_rdata              = rdata_reg;
    assign second_pulse           = sec_pulse_reg;
    assign interrupt_output_pin_n = pulse_n_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_len_slow_code: assert property (sec_end && idx_next == 6'h00 && corr_kind(trim_reg[6:0]) == CORR_SLOW
        |=> int'(len_reg) == TICKS_PER_SEC + 2 * (int'($past(trim_reg[6:0])) - 1)) // [RL5]
        else $error("slow second has wrong length");
    a_len_fast_code: assert property (sec_end && idx_next == 6'h00 && corr_kind(trim_reg[6:0]) == CORR_FAST
        |=> int'(len_reg) == TICKS_PER_SEC - 2 * (128 - int'($past(trim_reg[6:0])))) // [RL6]
        else $error("fast second has wrong length");
    a_len_off_codes: assert property (sec_end && trim_reg[5:1] == 5'h00
        |=> int'(len_reg) == TICKS_PER_SEC) // [RL3]
        else $error("disabled code altered a second");
    a_len_plain_sec: assert property (sec_end && idx_next != 6'h00
        |=> int'(len_reg) == TICKS_PER_SEC) // [RL14]
        else $error("non-corrected second altered");
    // Index may sit above 19 after a switch to the short period; it must fold at the next second end
    a_period_short: assert property (sec_end && !period_sel |=> sec_idx_reg < 6'h14) // [RL1]
        else $error("index past 20 second period");
    a_period_long: assert property (sec_end && period_sel && sec_idx_reg == 6'h13
        |=> sec_idx_reg == 6'h14) // [RL2]
        else $error("60 second period wrapped at 20");
    a_idx_wrap: assert property (sec_end && sec_idx_reg == period - 6'h01
        |=> sec_idx_reg == 6'h00) // [RL11]
        else $error("period did not wrap");
    a_power_clear: assert property (power_up_flag |=> trim_reg == 8'h00 && ctrl1_reg == 8'h00) // [RL13]
        else $error("power-up did not clear trim");
    a_pulse_off: assert property (!pulse_en |=> interrupt_output_pin_n) // [RL10]
        else $error("pulse output active while disabled");
    a_pulse_low: assert property (pulse_en && tick_cnt_reg == '0 |=> !interrupt_output_pin_n) // [RL10]
        else $error("pulse output missed second start");
    a_cnt_bound: assert property (tick_cnt_reg < len_reg) // [RL14]
        else $error("prescaler overran second length");
    a_slow_longer: assert property (sec_end && idx_next == 6'h00 && corr_kind(trim_reg[6:0]) == CORR_SLOW
        |=> int'(len_reg) > TICKS_PER_SEC) // [RL5]
        else $error("gain correction did not lengthen second");
    a_fast_shorter: assert property (sec_end && idx_next == 6'h00 && corr_kind(trim_reg[6:0]) == CORR_FAST
        |=> int'(len_reg) < TICKS_PER_SEC) // [RL6]
        else $error("loss correction did not shorten second");

    // Register bus
    a_write_trim: assert property (reg_wr && trim_sel && !power_up_flag |=> trim_reg == $past(reg_wdata)) // [RL4]
        else $error("trim write lost");
    a_write_ctrl1: assert property (reg_wr && ctrl1_sel && !power_up_flag |=> ctrl1_reg == $past(reg_wdata)) // [RL10]
        else $error("control write lost");
    a_trim_hold: assert property (!reg_wr && !power_up_flag |=> $stable(trim_reg)) // [RL4]
        else $error("trim changed without write");
    a_ctrl1_hold: assert property (!reg_wr && !power_up_flag |=> $stable(ctrl1_reg)) // [RL10]
        else $error("control changed without write");
    a_power_beats_wr: assert property (power_up_flag && reg_wr |=> trim_reg == 8'h00 && ctrl1_reg == 8'h00) // [RL13]
        else $error("write beat power-up clear");
    a_rdata_trim: assert property (trim_sel |=> reg_rdata == $past(trim_reg)) // [RL4]
        else $error("trim read back wrong");
    a_rdata_ctrl1: assert property (ctrl1_sel |=> reg_rdata == $past(ctrl1_reg)) // [RL10]
        else $error("control read back wrong");
    a_rdata_unmapped: assert property (!trim_sel && !ctrl1_sel |=> reg_rdata == 8'h00) // [RL4]
        else $error("unmapped read not zero");

    // Prescaler and second index
    a_cnt_advance: assert property (xtal_tick && !sec_end |=> tick_cnt_reg == $past(tick_cnt_reg) + 1'b1) // [RL14]
        else $error("prescaler missed a tick");
    a_cnt_idle: assert property (!xtal_tick |=> $stable(tick_cnt_reg) && $stable(len_reg)) // [RL14]
        else $error("prescaler moved without tick");
    a_cnt_restart: assert property (sec_end |=> tick_cnt_reg == '0) // [RL14]
        else $error("prescaler did not restart");
    a_len_held: assert property (!sec_end |=> $stable(len_reg)) // [RL14]
        else $error("second length changed mid-second");
    a_sec_pulse: assert property (sec_end |=> second_pulse) // [RL11]
        else $error("second pulse missing");
    a_sec_pulse_gap: assert property (!sec_end |=> !second_pulse) // [RL11]
        else $error("spurious second pulse");
    a_idx_hold: assert property (!sec_end |=> $stable(sec_idx_reg)) // [RL1] [RL2]
        else $error("index moved mid-second");
    a_idx_step: assert property (sec_end && sec_idx_reg < period - 6'h01
        |=> sec_idx_reg == $past(sec_idx_reg) + 6'h01) // [RL1] [RL2]
        else $error("index did not advance");
    a_period_long_max: assert property (sec_end && period_sel |=> sec_idx_reg < 6'h3c) // [RL2]
        else $error("index past 60 second period");

    // Pulse output duty
    a_pulse_half: assert property (pulse_en && !first_half |=> interrupt_output_pin_n) // [RL10]
        else $error("pulse output low in second half");
    a_pulse_first_half: assert property (pulse_en && first_half |=> !interrupt_output_pin_n) // [RL10]
        else $error("pulse output high in first half");

    c_slow_second: cover property (sec_end && idx_next == 6'h00 && corr_kind(trim_reg[6:0]) == CORR_SLOW);
    c_fast_second: cover property (sec_end && idx_next == 6'h00 && corr_kind(trim_reg[6:0]) == CORR_FAST);
    c_long_wrap:   cover property (sec_end && period_sel && sec_idx_reg == 6'h3b);
    c_pulse_mode:  cover property (pulse_en && $fell(interrupt_output_pin_n));
    c_power_clear: cover property (power_up_flag && trim_reg != 8'h00);
endmodule

/* File: testbench/tb_rtc_second_trim_unit.sv */
// Purpose: Self-checking bench for the one-second trim unit
// Assumes: xtal_tick held high after reset, so one prescaler tick per clk
// Notes:   Short second (T=128) keeps every code's length positive
`timescale 1ns/1ps
module tb_rtc_second_trim_unit;
    import rtc_trim_pkg::*;
    localparam int T = 128;
    logic       clk, arst_n, xtal_tick, power_up_flag, reg_wr;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic       second_pulse, interrupt_output_pin_n;
    int         num_errors, n_tests, c, dev, got;
    typedef struct { logic [7:0] val; int len; } row_t;
    // Host-formula codes within -62..63, plus the disable codes
    row_t rows [11] = '{'{8'h09, T+16}, '{8'h46, T-116}, '{8'h3f, T+124}, '{8'h42, T-124},
        '{8'h7f, T-2}, '{8'h00, T}, '{8'h01, T}, '{8'h40, T}, '{8'h41, T}, '{8'h99, T+48}, '{8'h82, T+2}};
    rtc_second_trim_unit #(.TICKS_PER_SEC(T)) DUT (.clk(clk), .arst_n(arst_n), .xtal_tick(xtal_tick),
        .power_up_flag(power_up_flag), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .second_pulse(second_pulse), .interrupt_output_pin_n(interrupt_output_pin_n));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        repeat (2) @(negedge clk);
        check(32'(reg_rdata), 32'(e));
    endtask
    // Cycles up to and including the next second pulse; bounded against a hang
    task sec(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (second_pulse !== 1'b1 && n < 400);
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25ns * 100000);
        num_errors++;
        test_done();
    end
    initial begin
        num_errors = 0; n_tests = 0;
        arst_n = 1'b0; xtal_tick = 1'b0; power_up_flag = 1'b0;
        reg_addr = 4'h0; reg_wr = 1'b0; reg_wdata = 8'h00;
        repeat (16) @(negedge clk);
        arst_n = 1'b1; xtal_tick = 1'b1;
        rd(4'h7, 8'h00);
        $display("Reset test done");
        for (int i = 0; i < 11; i++) begin
            wr(4'h7, rows[i].val);
            rd(4'h7, rows[i].val);
            sec(c);
            sec(c);
            dev = 0; got = 0;
            // Any full period holds exactly one corrected second, none for the disable codes, wherever the index stands
            for (int j = 0; j < (rows[i].val[7] ? 60 : 20); j++) begin
                sec(c);
                if (c != T) begin dev++; got = c; end
            end
            check(32'(dev), 32'(rows[i].len != T));
            if (dev != 0) check(32'(got), 32'(rows[i].len));
            $display("Trim row %0d done", i);
        end
        wr(4'h7, 8'h00);
        foreach (rows[k]) if (k < 3) begin
            wr(4'he, k == 0 ? 8'h33 : k == 1 ? 8'h03 : 8'h43);
            sec(c);
            sec(c);
            repeat (4) @(negedge clk);
            check(32'(interrupt_output_pin_n), 32'(k == 2));
            repeat (T / 2 + 8) @(negedge clk);
            check(32'(interrupt_output_pin_n), 32'h1);
        end
        $display("Pulse output test done");
        wr(4'h5, 8'hff);
        rd(4'h5, 8'h00);
        wr(4'h7, 8'h99);
        wr(4'he, 8'h33);
        @(negedge clk);
        power_up_flag = 1'b1;
        @(negedge clk);
        power_up_flag = 1'b0;
        rd(4'h7, 8'h00);
        rd(4'he, 8'h00);
        $display("Power-up and unmapped test done");
        test_done();
    end
endmodule
